/* File: burst_counter.sv */
// Two-bit burst address generator, linear or interleaved
`timescale 1ns/10ps
module burst_counter (
  // Counter request and answer
  burst_if.cnt bus
);
  always_comb begin
    if (bus.interleave) begin
      bus.addr_low = bus.start_low ^ bus.count;
    end else begin
      bus.addr_low = 2'(bus.start_low + bus.count);
    end
  end
endmodule

/* File: burst_if.sv */
// Carrier between the cycle control and the burst counter
`timescale 1ns/10ps
interface burst_if;
  logic [1:0] start_low;
  logic [1:0] count;
  logic interleave;
  logic [1:0] addr_low;
  modport ctl (output start_low, output count, output interleave, input addr_low);
  modport cnt (input start_low, input count, input interleave, output addr_low);
endinterface

/* File: sram_ctl_pkg.sv */
// Shared constants and types for the burst SRAM cycle control
package sram_ctl_pkg;
  // Register byte offsets on the AXI4-Lite slave
  localparam logic [7:0] CTRL_OFFSET = 8'h00;
  localparam logic [7:0] STATUS_OFFSET = 8'h04;
  localparam logic [7:0] ADDR_OFFSET = 8'h08;
  // Field positions
  localparam int CTRL_WP_BIT = 0;
  localparam int ST_ASLEEP_BIT = 0;
  localparam int ST_ACTIVE_BIT = 1;
  localparam int ST_READ_BIT = 2;
  localparam int ST_ORDER_BIT = 3;
  localparam int ST_COUNT_LSB = 4;
  // Values after reset, the burst step and the lane masks
  localparam logic CTRL_WP_RESET = 1'b0;
  localparam logic [1:0] COUNT_RESET = 2'h0;
  localparam logic [1:0] COUNT_STEP = 2'h1;
  localparam logic [3:0] ALL_LANES = 4'hf;
  localparam logic [3:0] NO_LANES = 4'h0;
  // Bus answers
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // Last cycle type, Gray along idle, read, write
  typedef enum logic [1:0] {
    CYC_IDLE = 2'b00,
    CYC_READ = 2'b01,
    CYC_WRITE = 2'b11
  } cycle_e;
endpackage

/* File: sram_ctl_props.sv */
// Port-level checks for the burst SRAM cycle control
`timescale 1ns/10ps
module sram_ctl_props (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // Cycle controls and lanes
  input wire logic chip_enable_primary_n,
  input wire logic depth_enable_high,
  input wire logic depth_enable_low_n,
  input wire logic proc_addr_strobe_n,
  input wire logic ctrl_addr_strobe_n,
  input wire logic global_write_n,
  input wire logic output_enable_n,
  input wire logic sleep_request,
  input wire logic byte_lane_data_oe,
  // Bus handshakes
  input wire logic s_axi_awready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);
  logic en_ok;
  assign en_ok = !chip_enable_primary_n && depth_enable_high && !depth_enable_low_n;
  // Sleep synchroniser has settled low
  sequence awake;
    !sleep_request [*3];
  endsequence
  a_sleep_floats: assert property (sleep_request |-> !byte_lane_data_oe)
    else $error("lanes driven in sleep");
  a_oe_async: assert property (byte_lane_data_oe |-> !output_enable_n)
    else $error("lanes driven without output enable");
  a_ctl_deselect: assert property (
    awake ##0 (!ctrl_addr_strobe_n && chip_enable_primary_n) |=> !byte_lane_data_oe)
    else $error("controller strobe did not deselect");
  a_depth_deselect: assert property (
    awake ##0 (!proc_addr_strobe_n && !chip_enable_primary_n
    && (depth_enable_low_n || !depth_enable_high)) |=> !byte_lane_data_oe)
    else $error("depth enables did not deselect");
  a_proc_read: assert property (
    awake ##0 (!proc_addr_strobe_n && en_ok) ##1 (!output_enable_n && !sleep_request)
    |-> byte_lane_data_oe)
    else $error("processor strobe did not read");
  a_write_floats: assert property (
    awake ##0 (proc_addr_strobe_n && !ctrl_addr_strobe_n && en_ok && !global_write_n)
    |=> !byte_lane_data_oe)
    else $error("lanes driven in write");
  a_aw_blocked: assert property (s_axi_bvalid |-> !s_axi_awready)
    else $error("write taken during response");
  a_ar_blocked: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken during response");
  c_read: cover property (!proc_addr_strobe_n && en_ok ##1 byte_lane_data_oe);
  c_deselect: cover property (!ctrl_addr_strobe_n && chip_enable_primary_n);
  c_sleep: cover property (sleep_request ##1 !sleep_request);
endmodule
bind sram_cycle_control sram_ctl_props u_props (.*);

/* File: sram_cycle_control.sv */
// Cycle control, array and register slave of the flow-through burst SRAM
//
// Added by the designer: the register offsets and the AXI4-Lite slave port.
`timescale 1ns/10ps
module sram_cycle_control #(
  parameter int ADDR_W = 17,
  parameter int LANES = 4
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // Synchronous SRAM controls
  input wire logic [ADDR_W-1:0] addr_in,
  input wire logic [LANES-1:0] byte_write_n,
  input wire logic global_write_n,
  input wire logic write_strobe_n,
  input wire logic chip_enable_primary_n,
  input wire logic depth_enable_high,
  input wire logic depth_enable_low_n,
  input wire logic proc_addr_strobe_n,
  input wire logic ctrl_addr_strobe_n,
  input wire logic burst_advance_n,
  // Asynchronous SRAM controls
  input wire logic output_enable_n,
  input wire logic burst_order_select,
  input wire logic sleep_request,
  // Data lanes, split two-way pin
  input wire logic [8*LANES-1:0] byte_lane_data_in,
  output logic [8*LANES-1:0] byte_lane_data_out,
  output logic byte_lane_data_oe,
  // AXI4-Lite write address and data
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);

  localparam int DW = 8 * LANES;
  localparam int DEPTH = 1 << ADDR_W;

  typedef struct packed {
    logic sleep_meta;
    logic sleep_sync;
    logic order_meta;
    logic order_sync;
    logic asleep;
    logic active;
    sram_ctl_pkg::cycle_e cycle;
    logic [ADDR_W-1:0] cur_addr;
    logic [1:0] count;
    logic write_protect;
    logic aw_held;
    logic [7:0] aw_addr;
    logic w_held;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } state_s;

  state_s st;
  state_s next_st;

  logic [DW-1:0] mem [DEPTH];
  logic mem_we;
  logic [ADDR_W-1:0] mem_idx;
  logic [LANES-1:0] mem_lanes;

  burst_if cnt_bus ();

  burst_counter u_burst_counter (
    .bus(cnt_bus.cnt)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Burst address of the next beat

  assign cnt_bus.interleave = st.order_sync;
  assign cnt_bus.start_low = st.cur_addr[1:0] ^ (st.order_sync ? st.count : 2'h0);
  assign cnt_bus.count = st.order_sync ? 2'(st.count + sram_ctl_pkg::COUNT_STEP)
                                       : sram_ctl_pkg::COUNT_STEP;

  ////////////////////////////////////////////////////////////////////////////////
  // Data pins

  assign byte_lane_data_oe = st.active && (st.cycle == sram_ctl_pkg::CYC_READ) &&
                             !output_enable_n && !sleep_request && !st.asleep;
  assign byte_lane_data_out = mem[st.cur_addr];

  ////////////////////////////////////////////////////////////////////////////////
  // Bus handshakes

  assign s_axi_awready = !st.aw_held && !st.bvalid;
  assign s_axi_wready = !st.w_held && !st.bvalid;
  assign s_axi_arready = !st.rvalid;
  assign s_axi_bvalid = st.bvalid;
  assign s_axi_bresp = st.bresp;
  assign s_axi_rvalid = st.rvalid;
  assign s_axi_rdata = st.rdata;
  assign s_axi_rresp = st.rresp;

  ////////////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    logic enables_ok;
    logic [LANES-1:0] wr_lanes;
    logic [ADDR_W-1:0] next_addr;
    logic aw_ok;
    logic w_ok;
    logic [7:0] aw_a;
    logic [31:0] wd;
    logic [3:0] ws;
    enables_ok = 1'b0;
    wr_lanes = '0;
    next_addr = '0;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    aw_a = '0;
    wd = '0;
    ws = '0;
    next_st = st;
    mem_we = 1'b0;
    mem_idx = st.cur_addr;
    mem_lanes = '0;

    next_st.sleep_meta = sleep_request;
    next_st.sleep_sync = st.sleep_meta;
    next_st.order_meta = burst_order_select;
    next_st.order_sync = st.order_meta;

    enables_ok = !chip_enable_primary_n && depth_enable_high && !depth_enable_low_n;
    if (!global_write_n) begin
      wr_lanes = LANES'(sram_ctl_pkg::ALL_LANES);
    end else if (!write_strobe_n) begin
      wr_lanes = ~byte_write_n;
    end else begin
      wr_lanes = LANES'(sram_ctl_pkg::NO_LANES);
    end
    next_addr = {st.cur_addr[ADDR_W-1:2], cnt_bus.addr_low};

    if (st.sleep_sync) begin
      next_st.asleep = 1'b1;
    end else if (!ctrl_addr_strobe_n && chip_enable_primary_n) begin
      next_st.active = 1'b0;
      next_st.cycle = sram_ctl_pkg::CYC_IDLE;
    end else if (!proc_addr_strobe_n && !chip_enable_primary_n) begin
      if (enables_ok) begin
        next_st.active = 1'b1;
        next_st.asleep = 1'b0;
        next_st.cycle = sram_ctl_pkg::CYC_READ;
        next_st.cur_addr = addr_in;
        next_st.count = sram_ctl_pkg::COUNT_RESET;
      end else begin
        next_st.active = 1'b0;
        next_st.cycle = sram_ctl_pkg::CYC_IDLE;
      end
    end else if (!ctrl_addr_strobe_n) begin
      if (enables_ok) begin
        next_st.active = 1'b1;
        next_st.asleep = 1'b0;
        next_st.cur_addr = addr_in;
        next_st.count = sram_ctl_pkg::COUNT_RESET;
        next_st.cycle = (|wr_lanes) ? sram_ctl_pkg::CYC_WRITE : sram_ctl_pkg::CYC_READ;
        mem_we = |wr_lanes;
        mem_idx = addr_in;
      end else begin
        next_st.active = 1'b0;
        next_st.cycle = sram_ctl_pkg::CYC_IDLE;
      end
    // bursts wait for a new command after sleep
    end else if (st.active && !st.asleep) begin
      next_st.cycle = (|wr_lanes) ? sram_ctl_pkg::CYC_WRITE : sram_ctl_pkg::CYC_READ;
      mem_we = |wr_lanes;
      if (!burst_advance_n) begin
        next_st.cur_addr = next_addr;
        next_st.count = 2'(st.count + sram_ctl_pkg::COUNT_STEP);
        mem_idx = next_addr;
      end else begin
        mem_idx = st.cur_addr;
      end
    end
    mem_lanes = st.write_protect ? LANES'(sram_ctl_pkg::NO_LANES) : wr_lanes;
    mem_we = mem_we && !st.write_protect;

    // Register writes: address and data in either order
    aw_ok = st.aw_held || (s_axi_awvalid && s_axi_awready);
    w_ok = st.w_held || (s_axi_wvalid && s_axi_wready);
    aw_a = st.aw_held ? st.aw_addr : s_axi_awaddr;
    wd = st.w_held ? st.w_data : s_axi_wdata;
    ws = st.w_held ? st.w_strb : s_axi_wstrb;
    if (st.bvalid && s_axi_bready) begin
      next_st.bvalid = 1'b0;
    end
    if (aw_ok && w_ok) begin
      next_st.aw_held = 1'b0;
      next_st.w_held = 1'b0;
      next_st.bvalid = 1'b1;
      if (aw_a == sram_ctl_pkg::CTRL_OFFSET) begin
        next_st.bresp = sram_ctl_pkg::RESP_OKAY;
        if (ws[0]) begin
          next_st.write_protect = wd[sram_ctl_pkg::CTRL_WP_BIT];
        end
      end else if (aw_a == sram_ctl_pkg::STATUS_OFFSET || aw_a == sram_ctl_pkg::ADDR_OFFSET) begin
        next_st.bresp = sram_ctl_pkg::RESP_OKAY;
      end else begin
        next_st.bresp = sram_ctl_pkg::RESP_SLVERR;
      end
    end else begin
      next_st.aw_held = aw_ok;
      next_st.aw_addr = aw_a;
      next_st.w_held = w_ok;
      next_st.w_data = wd;
      next_st.w_strb = ws;
    end

    // Register reads
    if (st.rvalid && s_axi_rready) begin
      next_st.rvalid = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      next_st.rvalid = 1'b1;
      next_st.rresp = sram_ctl_pkg::RESP_OKAY;
      next_st.rdata = '0;
      if (s_axi_araddr == sram_ctl_pkg::CTRL_OFFSET) begin
        next_st.rdata[sram_ctl_pkg::CTRL_WP_BIT] = st.write_protect;
      end else if (s_axi_araddr == sram_ctl_pkg::STATUS_OFFSET) begin
        next_st.rdata[sram_ctl_pkg::ST_ASLEEP_BIT] = st.asleep;
        next_st.rdata[sram_ctl_pkg::ST_ACTIVE_BIT] = st.active;
        next_st.rdata[sram_ctl_pkg::ST_READ_BIT] = (st.cycle == sram_ctl_pkg::CYC_READ);
        next_st.rdata[sram_ctl_pkg::ST_ORDER_BIT] = st.order_sync;
        next_st.rdata[sram_ctl_pkg::ST_COUNT_LSB +: 2] = st.count;
      end else if (s_axi_araddr == sram_ctl_pkg::ADDR_OFFSET) begin
        next_st.rdata[ADDR_W-1:0] = st.cur_addr;
      end else begin
        next_st.rresp = sram_ctl_pkg::RESP_SLVERR;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // State registers

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      st <= '0;
      st.write_protect <= sram_ctl_pkg::CTRL_WP_RESET;
      st.count <= sram_ctl_pkg::COUNT_RESET;
      st.cycle <= sram_ctl_pkg::CYC_IDLE;
    end else begin
      st <= next_st;
    end
  end

  always_ff @(posedge core_clk) begin
    for (int i = 0; i < LANES; i++) begin
      if (mem_we && mem_lanes[i]) begin
        mem[mem_idx][8*i +: 8] <= byte_lane_data_in[8*i +: 8];
      end
    end
  end

endmodule

/* File: sram_host.sv */
// Controller model driving the SRAM cycle pins
`timescale 1ns/10ps
module sram_host #(
  parameter int AW = 6
) (
  // Clock
  input wire logic core_clk,
  // Cycle pins
  output logic [AW-1:0] addr_in,
  output logic [3:0] byte_write_n,
  output logic global_write_n,
  output logic write_strobe_n,
  output logic chip_enable_primary_n,
  output logic depth_enable_high,
  output logic depth_enable_low_n,
  output logic proc_addr_strobe_n,
  output logic ctrl_addr_strobe_n,
  output logic burst_advance_n,
  output logic output_enable_n,
  // Write data
  output logic [31:0] host_data
);
  initial begin
    {chip_enable_primary_n, depth_enable_high, depth_enable_low_n, proc_addr_strobe_n,
      ctrl_addr_strobe_n, burst_advance_n, global_write_n, write_strobe_n,
      byte_write_n} = 12'h5ff;
    output_enable_n = 1'b1;
    addr_in = '0;
    host_data = 32'h0000_0000;
  end
  // One command word per cycle, launched at the rising edge
  task automatic cyc(input logic [11:0] c, input logic g, input logic [AW-1:0] a,
                     input logic [31:0] d);
    logic w;
    w = !c[5] || (!c[4] && c[3:0] != 4'hf);
    @(posedge core_clk);
    {chip_enable_primary_n, depth_enable_high, depth_enable_low_n, proc_addr_strobe_n,
      ctrl_addr_strobe_n, burst_advance_n, global_write_n, write_strobe_n,
      byte_write_n} <= c;
    addr_in <= a;
    output_enable_n <= w || g;
    // Released data toggles so stale values never match
    host_data <= w ? d : ~host_data;
  endtask
endmodule

/* File: testbench.sv */
// Self-checking bench for the burst SRAM cycle control
`timescale 1ns/10ps
module testbench;
  localparam int AW = 6;
  // Enables, strobes, advance, global, normal, byte lanes
  localparam logic [11:0] GW = 12'h55f, GC = 12'h59f, BW = 12'h56d, PR = 12'h4df;
  localparam logic [11:0] CR = 12'h5bf, SU = 12'h5ff, D1 = 12'hc7f, D2 = 12'h6ff, D3 = 12'h0ff;
  logic core_clk = 1'b0, rst_n = 1'b0, sleep_request = 1'b0, burst_order_select = 1'b0;
  logic [AW-1:0] addr_in;
  logic [3:0] byte_write_n;
  logic global_write_n, write_strobe_n, chip_enable_primary_n, depth_enable_high;
  logic depth_enable_low_n, proc_addr_strobe_n, ctrl_addr_strobe_n, burst_advance_n;
  logic output_enable_n, byte_lane_data_oe;
  logic [31:0] byte_lane_data_in, byte_lane_data_out, host_data, s_axi_rdata;
  logic [31:0] s_axi_wdata = 32'h0000_0000;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] m [0:63];
  int err_count = 0, cmp_count = 0, cyc_n = 0;
  always #25 core_clk = ~core_clk;
  assign byte_lane_data_in = byte_lane_data_oe ? byte_lane_data_out : host_data;
  sram_cycle_control #(.ADDR_W(AW)) DUT (.*);
  sram_host #(.AW(AW)) host (.*);
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    cmp_count++;
    if (s !== e) begin
      err_count++;
      $display("[ERR] %s exp %h seen %h", n, e, s);
    end
  endtask
  task automatic finish_test();
    if (err_count == 0 && cmp_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // Launch a command, then check what the previous command left on the lanes
  task automatic step(input logic [11:0] c, input logic g, input logic [AW-1:0] a,
                      input logic [31:0] d, input logic eo, input logic [31:0] ed);
    host.cyc(c, g, a, d);
    #1;
    chk("oe", 32'(byte_lane_data_oe), 32'(eo));
    if (eo) chk("data", byte_lane_data_out, ed);
  endtask
  // Wait on a local flag: the valids set by non-blocking assignment are not yet visible
  task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    logic done;
    done = 1'b0;
    @(posedge core_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!done) begin
      @(posedge core_clk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) begin
        s_axi_bready <= 1'b0;
        chk("bresp", 32'(s_axi_bresp), 32'(r));
        done = 1'b1;
      end
    end
  endtask
  task automatic axr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    logic done;
    done = 1'b0;
    @(posedge core_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    while (!done) begin
      @(posedge core_clk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) begin
        s_axi_rready <= 1'b0;
        chk("rdata", s_axi_rdata, d);
        chk("rresp", 32'(s_axi_rresp), 32'(r));
        done = 1'b1;
      end
    end
  endtask
  always @(posedge core_clk) begin
    cyc_n <= cyc_n + 1;
    if (cyc_n == 3000) begin
      err_count++;
      finish_test();
    end
  end
  initial begin
    repeat (16) @(posedge core_clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge core_clk);
    axr(sram_ctl_pkg::CTRL_OFFSET, 32'h0000_0000, sram_ctl_pkg::RESP_OKAY);
    axr(8'h10, 32'h0000_0000, sram_ctl_pkg::RESP_SLVERR);
    axw(8'h10, 32'h0000_0001, sram_ctl_pkg::RESP_SLVERR);
    // Global write burst from 6 wraps linearly 6, 7, 4, 5
    for (int i = 0; i < 4; i++) begin
      step(i == 0 ? GW : GC, 1'b1, 6'h06, 32'h1000_0000 + i, 1'b0, 0);
      m[4 + (i + 2) % 4] = 32'h1000_0000 + i;
    end
    step(BW, 1'b1, 6'h05, 32'hffff_abff, 1'b0, 0);
    m[5][15:8] = 8'hab;
    step(PR, 1'b0, 6'h04, 0, 1'b0, 0);
    step(CR, 1'b0, 6'h00, 0, 1'b1, m[4]);
    step(SU, 1'b0, 6'h00, 0, 1'b1, m[5]);
    step(CR, 1'b0, 6'h00, 0, 1'b1, m[5]);
    step(D1, 1'b0, 6'h00, 0, 1'b1, m[6]);
    step(D2, 1'b0, 6'h00, 0, 1'b0, 0);
    step(D3, 1'b0, 6'h00, 0, 1'b0, 0);
    step(SU, 1'b0, 6'h00, 0, 1'b0, 0);
    @(posedge core_clk) burst_order_select <= 1'b1;
    repeat (2) step(SU, 1'b0, 6'h00, 0, 1'b0, 0);
    step(PR, 1'b0, 6'h05, 0, 1'b0, 0);
    for (int i = 0; i < 3; i++) step(CR, 1'b0, 6'h00, 0, 1'b1, m[5 ^ i]);
    step(SU, 1'b1, 6'h00, 0, 1'b0, 0);
    step(PR, 1'b0, 6'h06, 0, 1'b0, 0);
    @(posedge core_clk) sleep_request <= 1'b1;
    step(SU, 1'b0, 6'h00, 0, 1'b0, 0);
    step(GW, 1'b1, 6'h06, 32'hdead_0000, 1'b0, 0);
    repeat (3) step(SU, 1'b1, 6'h00, 0, 1'b0, 0);
    @(posedge core_clk) sleep_request <= 1'b0;
    repeat (3) step(CR, 1'b1, 6'h00, 0, 1'b0, 0);
    step(PR, 1'b0, 6'h06, 0, 1'b0, 0);
    step(SU, 1'b0, 6'h00, 0, 1'b1, m[6]);
    axw(sram_ctl_pkg::CTRL_OFFSET, 32'h0000_0001, sram_ctl_pkg::RESP_OKAY);
    step(GW, 1'b1, 6'h07, 32'h5555_0000, 1'b0, 0);
    step(PR, 1'b0, 6'h07, 0, 1'b0, 0);
    step(SU, 1'b0, 6'h00, 0, 1'b1, m[7]);
    // Suspended interleaved read at 7: active, read, interleaved, no beats
    axr(sram_ctl_pkg::STATUS_OFFSET, 32'h0000_000e, sram_ctl_pkg::RESP_OKAY);
    axr(sram_ctl_pkg::ADDR_OFFSET, 32'h0000_0007, sram_ctl_pkg::RESP_OKAY);
    axw(sram_ctl_pkg::CTRL_OFFSET, 32'h0000_0000, sram_ctl_pkg::RESP_OKAY);
    axr(sram_ctl_pkg::CTRL_OFFSET, 32'h0000_0000, sram_ctl_pkg::RESP_OKAY);
    finish_test();
  end
endmodule
